// >>> psmcb_bank.sv
// manufacturer command register bank with trackers and fault-log readout
`timescale 1ns/100ps
module psmcb_bank #(
	// arbitrary neutral identification values
	parameter logic [15:0] PART_ID  = 16'h0A5A,
	parameter logic [63:0] LOT_CODE = 64'h0000_0000_0000_0000
) (
	// clock and reset
	input  wire logic                            clk_i,
	input  wire logic                            rstn_i,
	// decoded command port
	input  wire logic                            cmd_rd_i,
	input  wire logic                            cmd_wr_i,
	input  wire logic                            cmd_send_i,
	input  wire logic [7:0]                      cmd_code_i,
	input  wire logic [15:0]                     cmd_wdata_i,
	input  wire logic [7:0]                      page_i,
	output      logic                            rsp_valid_o,
	output      logic [15:0]                     rsp_data_o,
	output      logic                            rsp_err_o,
	// telemetry samples
	input  wire logic                            vout_valid_i,
	input  wire logic [2:0]                      vout_chan_i,
	input  wire logic [15:0]                     vout_i,
	input  wire logic                            vin_valid_i,
	input  wire logic [15:0]                     vin_i,
	input  wire logic                            temp_valid_i,
	input  wire logic [15:0]                     temp_i,
	// off threshold request
	input  wire logic                            vcmd_valid_i,
	input  wire logic [2:0]                      vcmd_chan_i,
	input  wire logic [15:0]                     vcmd_i,
	output      logic                            thr_valid_o,
	output      logic [2:0]                      thr_chan_o,
	output      logic [15:0]                     thr_o,
	// pads and device status
	input  wire logic [15:0]                     pads_i,
	input  wire logic [7:0]                      log_status_i,
	input  wire logic [7:0]                      shared_status_i,
	// fault log ram fill
	input  wire logic                            log_wr_i,
	input  wire logic [7:0]                      log_waddr_i,
	input  wire logic [7:0]                      log_wdata_i,
	// fault log engine strobes
	output      logic                            log_store_o,
	output      logic                            fault_off_o,
	output      logic                            log_restore_o,
	output      logic                            log_clear_o,
	// configuration to the rest of the device
	output      logic [4*8-1:0]                  fault_pin_resp_o,
	output      logic [7:0]                      inen_ov_resp_o,
	output      logic [7:0]                      inen_uv_resp_o,
	output      logic [15:0]                     retry_intv_o,
	output      logic [15:0]                     restart_intv_o,
	output      logic [15:0]                     pgood_delay_o,
	output      logic [15:0]                     wdog_first_o,
	output      logic [15:0]                     wdog_intv_o,
	output      logic [7:0]                      page_mask_o,
	output      logic [7:0]                      base_addr_o,
	output      logic [7:0]                      retry_limit_o,
	output      logic [psmcb_pkg::NUM_PAGES*psmcb_pkg::DAC_BITS-1:0] dac_o
);
	import psmcb_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// exponent-mantissa word to signed fixed point, 16 fraction bits
	function automatic logic signed [42:0] l11_fix(input logic [15:0] w);
		logic signed [42:0] m;
		logic [4:0]         e;
		m = 43'(signed'(w[L11_MANT_BITS-1:0]));
		e = w[15:L11_EXP_LSB] ^ L11_EXP_BIAS;
		l11_fix = m <<< e;
	endfunction

	// unsigned voltage word times coefficient, saturated
	function automatic logic [15:0] thr_calc(input logic [15:0] v,
	                                        input logic [15:0] c);
		logic signed [59:0] p;
		logic [4:0]         e;
		p = 60'(signed'({1'b0, v}) * signed'(c[L11_MANT_BITS-1:0]));
		e = c[15:L11_EXP_LSB] ^ L11_EXP_BIAS;
		p = (p <<< e) >>> FIX_FRAC;
		if (p < 0)
			thr_calc = RST_WORD_ZERO;
		else if (p > 60'(VOUT_MAX))
			thr_calc = VOUT_MAX;
		else
			thr_calc = p[15:0];
	endfunction

	// ------------------------------------------------------------
	// reset release and pad synchroniser
	// ------------------------------------------------------------
	logic [1:0]  rst_sync_r;
	logic        rst_n;
	logic [15:0] pads_meta_r;
	logic [15:0] pads_r;

	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			pads_meta_r <= RST_WORD_ZERO;
			pads_r      <= RST_WORD_ZERO;
		end
		else
		begin
			pads_meta_r <= pads_i;
			pads_r      <= pads_meta_r;
		end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire         page_ok  = (page_i <= PAGE_LAST);
	wire [2:0]   pg       = page_i[2:0];
	wire         is_paged = (cmd_code_i == CMD_VOUT_PEAK)
	                      || (cmd_code_i == CMD_TRIM_DAC)
	                      || (cmd_code_i == CMD_LOT_CODE)
	                      || (cmd_code_i == CMD_OFF_COEFF)
	                      || (cmd_code_i == CMD_VOUT_MIN);
	wire         bad_page = is_paged && !page_ok;
	wire         wr_go    = cmd_wr_i && !bad_page;

	// ------------------------------------------------------------
	// writable registers
	// ------------------------------------------------------------
	logic [7:0]  fresp_r [4];
	logic [7:0]  inen_ov_r, inen_uv_r, page_mask_r, base_addr_r;
	logic [7:0]  retry_lim_r;
	logic [15:0] retry_intv_r, restart_r, pgood_r, wdog_first_r, wdog_r;
	logic [DAC_BITS-1:0] dac_r [NUM_PAGES];
	logic [15:0] coeff_r [NUM_PAGES];
	logic        wr_known;

	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			for (int i = 0; i < 4; i++)
				fresp_r[i] <= RST_FAULT_RESP;
			inen_ov_r    <= RST_INEN_RESP;
			inen_uv_r    <= RST_INEN_RESP;
			retry_intv_r <= RST_RETRY_INTV;
			restart_r    <= RST_RESTART_INTV;
			pgood_r      <= RST_PGOOD_DELAY;
			wdog_first_r <= RST_WDOG;
			wdog_r       <= RST_WDOG;
			page_mask_r  <= RST_PAGE_MASK;
			base_addr_r  <= RST_BASE_ADDR;
			retry_lim_r  <= RST_RETRY_LIMIT;
			for (int i = 0; i < NUM_PAGES; i++)
			begin
				dac_r[i]   <= DAC_BITS'(RST_WORD_ZERO);
				coeff_r[i] <= RST_OFF_COEFF;
			end
		end
		else if (wr_go)
		begin
			if (cmd_code_i >= CMD_FAULT_PIN00 && cmd_code_i <= CMD_FAULT_PIN11)
				fresp_r[2'(cmd_code_i - CMD_FAULT_PIN00)] <= cmd_wdata_i[7:0];
			else if (cmd_code_i == CMD_INEN_OV_RESP)
				inen_ov_r <= cmd_wdata_i[7:0];
			else if (cmd_code_i == CMD_INEN_UV_RESP)
				inen_uv_r <= cmd_wdata_i[7:0];
			else if (cmd_code_i == CMD_RETRY_INTV)
				retry_intv_r <= cmd_wdata_i;
			else if (cmd_code_i == CMD_RESTART_INTV)
				restart_r <= cmd_wdata_i;
			else if (cmd_code_i == CMD_TRIM_DAC)
				dac_r[pg] <= cmd_wdata_i[DAC_BITS-1:0];
			else if (cmd_code_i == CMD_PGOOD_DELAY)
				pgood_r <= cmd_wdata_i;
			else if (cmd_code_i == CMD_WDOG_FIRST)
				wdog_first_r <= cmd_wdata_i;
			else if (cmd_code_i == CMD_WDOG_INTV)
				wdog_r <= cmd_wdata_i;
			else if (cmd_code_i == CMD_PAGE_MASK)
				page_mask_r <= cmd_wdata_i[7:0];
			else if (cmd_code_i == CMD_BASE_ADDR)
				base_addr_r <= cmd_wdata_i[7:0];
			else if (cmd_code_i == CMD_OFF_COEFF)
				coeff_r[pg] <= cmd_wdata_i;
			else if (cmd_code_i == CMD_RETRY_LIMIT)
				retry_lim_r <= cmd_wdata_i[7:0];
		end

	assign wr_known = (cmd_code_i >= CMD_FAULT_PIN00
	                   && cmd_code_i <= CMD_RESTART_INTV)
	                || (cmd_code_i >= CMD_TRIM_DAC
	                   && cmd_code_i <= CMD_PAGE_MASK)
	                || (cmd_code_i == CMD_BASE_ADDR)
	                || (cmd_code_i == CMD_OFF_COEFF)
	                || (cmd_code_i == CMD_RETRY_LIMIT);

	// ------------------------------------------------------------
	// telemetry trackers
	// ------------------------------------------------------------
	// empty trackers read zero until the first sample arrives
	logic [15:0] vpk_r [NUM_PAGES];
	logic [15:0] vmn_r [NUM_PAGES];
	logic [NUM_PAGES-1:0] vseen_r;
	logic [15:0] vinpk_r, vinmn_r, tpk_r, tmn_r;
	logic        vinseen_r, tseen_r;

	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_PAGES; i++)
			begin
				vpk_r[i] <= RST_WORD_ZERO;
				vmn_r[i] <= RST_WORD_ZERO;
			end
			vseen_r   <= '0;
			vinpk_r   <= RST_WORD_ZERO;
			vinmn_r   <= RST_WORD_ZERO;
			tpk_r     <= RST_WORD_ZERO;
			tmn_r     <= RST_WORD_ZERO;
			vinseen_r <= 1'b0;
			tseen_r   <= 1'b0;
		end
		else
		begin
			if (vout_valid_i)
			begin
				vseen_r[vout_chan_i] <= 1'b1;
				if (!vseen_r[vout_chan_i] || vout_i > vpk_r[vout_chan_i])
					vpk_r[vout_chan_i] <= vout_i;
				if (!vseen_r[vout_chan_i] || vout_i < vmn_r[vout_chan_i])
					vmn_r[vout_chan_i] <= vout_i;
			end
			if (vin_valid_i)
			begin
				vinseen_r <= 1'b1;
				if (!vinseen_r || l11_fix(vin_i) > l11_fix(vinpk_r))
					vinpk_r <= vin_i;
				if (!vinseen_r || l11_fix(vin_i) < l11_fix(vinmn_r))
					vinmn_r <= vin_i;
			end
			if (temp_valid_i)
			begin
				tseen_r <= 1'b1;
				if (!tseen_r || l11_fix(temp_i) > l11_fix(tpk_r))
					tpk_r <= temp_i;
				if (!tseen_r || l11_fix(temp_i) < l11_fix(tmn_r))
					tmn_r <= temp_i;
			end
		end

	// ------------------------------------------------------------
	// fault log ram and readout
	// ------------------------------------------------------------
	logic [7:0] log_mem [LOG_DATA_LEN];
	logic [7:0] log_idx_r;
	wire        log_rd   = cmd_rd_i && (cmd_code_i == CMD_LOG_READOUT);
	wire [7:0]  log_byte = (log_idx_r == 8'h00) ? LOG_LEAD_BYTE
	                     : log_mem[log_idx_r - 8'h01];

	// ram has no reset: contents come from the logging engine
	always_ff @(posedge clk_i)
		if (log_wr_i && log_waddr_i < 8'(LOG_DATA_LEN))
			log_mem[log_waddr_i] <= log_wdata_i;

	// any other command restarts the readout at the lead byte
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
			log_idx_r <= 8'h00;
		else if (log_rd)
			log_idx_r <= log_idx_r + 8'h01;
		else if (cmd_rd_i || cmd_wr_i || cmd_send_i)
			log_idx_r <= 8'h00;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [15:0] rd_data;
	logic        rd_known;

	always_comb
	begin
		rd_data  = RST_WORD_ZERO;
		rd_known = 1'b1;
		if (cmd_code_i >= CMD_FAULT_PIN00 && cmd_code_i <= CMD_FAULT_PIN11)
			rd_data = {8'h00, fresp_r[2'(cmd_code_i - CMD_FAULT_PIN00)]};
		else if (cmd_code_i == CMD_INEN_OV_RESP)
			rd_data = {8'h00, inen_ov_r};
		else if (cmd_code_i == CMD_INEN_UV_RESP)
			rd_data = {8'h00, inen_uv_r};
		else if (cmd_code_i == CMD_RETRY_INTV)
			rd_data = retry_intv_r;
		else if (cmd_code_i == CMD_RESTART_INTV)
			rd_data = restart_r;
		else if (cmd_code_i == CMD_VOUT_PEAK)
			rd_data = vpk_r[pg];
		else if (cmd_code_i == CMD_VIN_PEAK)
			rd_data = vinpk_r;
		else if (cmd_code_i == CMD_TEMP_PEAK)
			rd_data = tpk_r;
		else if (cmd_code_i == CMD_TRIM_DAC)
			rd_data = 16'(dac_r[pg]);
		else if (cmd_code_i == CMD_PGOOD_DELAY)
			rd_data = pgood_r;
		else if (cmd_code_i == CMD_WDOG_FIRST)
			rd_data = wdog_first_r;
		else if (cmd_code_i == CMD_WDOG_INTV)
			rd_data = wdog_r;
		else if (cmd_code_i == CMD_PAGE_MASK)
			rd_data = {8'h00, page_mask_r};
		else if (cmd_code_i == CMD_PAD_STATE)
			rd_data = pads_r;
		else if (cmd_code_i == CMD_BASE_ADDR)
			rd_data = {8'h00, base_addr_r};
		else if (cmd_code_i == CMD_PART_ID)
			rd_data = PART_ID;
		else if (cmd_code_i == CMD_LOT_CODE)
			rd_data = {8'h00, LOT_CODE[pg*8 +: 8]};
		else if (cmd_code_i == CMD_OFF_COEFF)
			rd_data = coeff_r[pg];
		else if (cmd_code_i == CMD_LOG_STATUS)
			rd_data = {8'h00, log_status_i};
		else if (cmd_code_i == CMD_LOG_READOUT)
			rd_data = {8'h00, log_byte};
		else if (cmd_code_i == CMD_SHARED_STATUS)
			rd_data = {8'h00, shared_status_i};
		else if (cmd_code_i == CMD_RETRY_LIMIT)
			rd_data = {8'h00, retry_lim_r};
		else if (cmd_code_i == CMD_VOUT_MIN)
			rd_data = vmn_r[pg];
		else if (cmd_code_i == CMD_VIN_MIN)
			rd_data = vinmn_r;
		else if (cmd_code_i == CMD_TEMP_MIN)
			rd_data = tmn_r;
		else
			rd_known = 1'b0;
	end

	wire send_known = (cmd_code_i >= CMD_LOG_STORE
	                   && cmd_code_i <= CMD_LOG_CLEAR);
	wire any_cmd    = cmd_rd_i || cmd_wr_i || cmd_send_i;
	wire cmd_err    = (cmd_rd_i && (!rd_known || bad_page))
	                || (cmd_wr_i && (!wr_known || bad_page))
	                || (cmd_send_i && !send_known);

	// ------------------------------------------------------------
	// answer, strobes and threshold
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			rsp_valid_o   <= 1'b0;
			rsp_data_o    <= RST_WORD_ZERO;
			rsp_err_o     <= 1'b0;
			log_store_o   <= 1'b0;
			fault_off_o   <= 1'b0;
			log_restore_o <= 1'b0;
			log_clear_o   <= 1'b0;
			thr_valid_o   <= 1'b0;
			thr_chan_o    <= 3'h0;
			thr_o         <= RST_WORD_ZERO;
		end
		else
		begin
			rsp_valid_o   <= any_cmd;
			rsp_data_o    <= (cmd_rd_i && !cmd_err) ? rd_data
			                                         : RST_WORD_ZERO;
			rsp_err_o     <= cmd_err;
			log_store_o   <= cmd_send_i && cmd_code_i == CMD_LOG_STORE;
			fault_off_o   <= cmd_send_i && cmd_code_i == CMD_LOG_STORE;
			log_restore_o <= cmd_send_i
			                 && cmd_code_i == CMD_LOG_RESTORE;
			log_clear_o   <= cmd_send_i && cmd_code_i == CMD_LOG_CLEAR;
			thr_valid_o   <= vcmd_valid_i;
			if (vcmd_valid_i)
			begin
				thr_chan_o <= vcmd_chan_i;
				thr_o      <= thr_calc(vcmd_i, coeff_r[vcmd_chan_i]);
			end
		end

	// ------------------------------------------------------------
	// configuration outputs
	// ------------------------------------------------------------
	// plain copies of the holding flops, no extra logic between
	assign fault_pin_resp_o = {fresp_r[3], fresp_r[2], fresp_r[1], fresp_r[0]};
	assign inen_ov_resp_o   = inen_ov_r;
	assign inen_uv_resp_o   = inen_uv_r;
	assign retry_intv_o     = retry_intv_r;
	assign restart_intv_o   = restart_r;
	assign pgood_delay_o    = pgood_r;
	assign wdog_first_o     = wdog_first_r;
	assign wdog_intv_o      = wdog_r;
	assign page_mask_o      = page_mask_r;
	assign base_addr_o      = base_addr_r;
	assign retry_limit_o    = retry_lim_r;
	assign dac_o            = {dac_r[7], dac_r[6], dac_r[5], dac_r[4],
	                           dac_r[3], dac_r[2], dac_r[1], dac_r[0]};

endmodule // psmcb_bank

// >>> psmcb_pkg.sv
// constants for the manufacturer command bank of the power system manager
package psmcb_pkg;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_FAULT_PIN00   = 8'hD5;
	localparam logic [7:0] CMD_FAULT_PIN01   = 8'hD6;
	localparam logic [7:0] CMD_FAULT_PIN10   = 8'hD7;
	localparam logic [7:0] CMD_FAULT_PIN11   = 8'hD8;
	localparam logic [7:0] CMD_INEN_OV_RESP  = 8'hD9;
	localparam logic [7:0] CMD_INEN_UV_RESP  = 8'hDA;
	localparam logic [7:0] CMD_RETRY_INTV    = 8'hDB;
	localparam logic [7:0] CMD_RESTART_INTV  = 8'hDC;
	localparam logic [7:0] CMD_VOUT_PEAK     = 8'hDD;
	localparam logic [7:0] CMD_VIN_PEAK      = 8'hDE;
	localparam logic [7:0] CMD_TEMP_PEAK     = 8'hDF;
	localparam logic [7:0] CMD_TRIM_DAC      = 8'hE0;
	localparam logic [7:0] CMD_PGOOD_DELAY   = 8'hE1;
	localparam logic [7:0] CMD_WDOG_FIRST    = 8'hE2;
	localparam logic [7:0] CMD_WDOG_INTV     = 8'hE3;
	localparam logic [7:0] CMD_PAGE_MASK     = 8'hE4;
	localparam logic [7:0] CMD_PAD_STATE     = 8'hE5;
	localparam logic [7:0] CMD_BASE_ADDR     = 8'hE6;
	localparam logic [7:0] CMD_PART_ID       = 8'hE7;
	localparam logic [7:0] CMD_LOT_CODE      = 8'hE8;
	localparam logic [7:0] CMD_OFF_COEFF     = 8'hE9;
	localparam logic [7:0] CMD_LOG_STORE     = 8'hEA;
	localparam logic [7:0] CMD_LOG_RESTORE   = 8'hEB;
	localparam logic [7:0] CMD_LOG_CLEAR     = 8'hEC;
	localparam logic [7:0] CMD_LOG_STATUS    = 8'hED;
	localparam logic [7:0] CMD_LOG_READOUT   = 8'hEE;
	localparam logic [7:0] CMD_SHARED_STATUS = 8'hEF;
	localparam logic [7:0] CMD_RETRY_LIMIT   = 8'hF7;
	localparam logic [7:0] CMD_VOUT_MIN      = 8'hFB;
	localparam logic [7:0] CMD_VIN_MIN       = 8'hFC;
	localparam logic [7:0] CMD_TEMP_MIN      = 8'hFD;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_FAULT_RESP   = 8'h00;
	localparam logic [7:0]  RST_INEN_RESP    = 8'h00;
	localparam logic [15:0] RST_RETRY_INTV   = 16'hF320;
	localparam logic [15:0] RST_RESTART_INTV = 16'hFB20;
	localparam logic [15:0] RST_PGOOD_DELAY  = 16'hEB20;
	localparam logic [15:0] RST_WDOG         = 16'h8000;
	localparam logic [7:0]  RST_PAGE_MASK    = 8'hFF;
	localparam logic [7:0]  RST_BASE_ADDR    = 8'h5C;
	localparam logic [15:0] RST_OFF_COEFF    = 16'hC200;
	localparam logic [7:0]  RST_RETRY_LIMIT  = 8'h07;
	localparam logic [15:0] RST_WORD_ZERO    = 16'h0000;

	// ------------------------------------------------------------
	// fields, pages and sizes
	// ------------------------------------------------------------
	localparam int          NUM_PAGES     = 8;
	localparam logic [7:0]  PAGE_LAST     = 8'h07;
	localparam int          DAC_BITS      = 10;
	localparam int          L11_EXP_LSB   = 11;
	localparam int          L11_MANT_BITS = 11;
	localparam logic [4:0]  L11_EXP_BIAS  = 5'h10;
	localparam int          FIX_FRAC      = 16;
	localparam logic [7:0]  LOG_LEAD_BYTE = 8'hFF;
	localparam int          LOG_DATA_LEN  = 255;
	localparam logic [7:0]  LOG_IDX_LAST  = 8'hFF;
	localparam logic [15:0] VOUT_MAX      = 16'hFFFF;

endpackage : psmcb_pkg

// >>> psmcb_bank_monitor.sv
// port assertions for the manufacturer command bank
`timescale 1ns/100ps
module psmcb_chk (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rstn_i,
	// command port
	input wire logic        cmd_rd_i,
	input wire logic        cmd_wr_i,
	input wire logic        cmd_send_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [7:0]  page_i,
	input wire logic        vcmd_valid_i,
	// answers and strobes
	input wire logic        rsp_valid_o,
	input wire logic        rsp_err_o,
	input wire logic        thr_valid_o,
	input wire logic        log_store_o,
	input wire logic        fault_off_o,
	input wire logic        log_restore_o,
	input wire logic        log_clear_o,
	input wire logic [7:0]  page_mask_o,
	input wire logic [7:0]  retry_limit_o
);
	import psmcb_pkg::*;
	wire req = cmd_rd_i | cmd_wr_i | cmd_send_i;
	wire wr_mask = cmd_wr_i && cmd_code_i == CMD_PAGE_MASK;
	wire wr_rty = cmd_wr_i && cmd_code_i == CMD_RETRY_LIMIT;
	wire snd_st = cmd_send_i && cmd_code_i == CMD_LOG_STORE;
	wire snd_rs = cmd_send_i && cmd_code_i == CMD_LOG_RESTORE;
	wire snd_cl = cmd_send_i && cmd_code_i == CMD_LOG_CLEAR;
	wire dac_bad = req && cmd_code_i == CMD_TRIM_DAC && page_i > PAGE_LAST;
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	rsp_next_a: assert property (req |=> rsp_valid_o)
		else $error("no answer one cycle after a request");
	rsp_cause_a: assert property (rsp_valid_o |-> $past(req))
		else $error("answer without a request");
	store_pulse_a: assert property (snd_st |=> log_store_o && fault_off_o)
		else $error("store send gave no store and fault-off pulse");
	restore_only_a: assert property (snd_rs |=> log_restore_o && !fault_off_o)
		else $error("restore send gave wrong strobes");
	clear_pulse_a: assert property (snd_cl |=> log_clear_o ##1 log_clear_o == $past(snd_cl))
		else $error("clear send not a one-cycle pulse");
	mask_write_a: assert property (wr_mask |=> page_mask_o == $past(cmd_wdata_i[7:0]))
		else $error("channel mask not taken from write");
	mask_hold_a: assert property (!wr_mask |=> $stable(page_mask_o))
		else $error("channel mask changed without a write");
	retry_write_a: assert property (wr_rty |=> retry_limit_o == $past(cmd_wdata_i[7:0]))
		else $error("retry limit not taken from write");
	id_write_a: assert property (cmd_wr_i && cmd_code_i == CMD_PART_ID |=> rsp_err_o)
		else $error("write to identification word not refused");
	page_range_a: assert property (dac_bad |=> rsp_valid_o && rsp_err_o)
		else $error("paged access beyond last page not refused");
	thr_next_a: assert property (vcmd_valid_i |=> thr_valid_o)
		else $error("no threshold one cycle after command voltage");
	cover property (snd_st);
	cover property (dac_bad);
	cover property (cmd_rd_i && cmd_code_i == CMD_LOG_READOUT);
endmodule // psmcb_chk

bind psmcb_bank psmcb_chk u_chk (.clk_i, .rstn_i, .cmd_rd_i, .cmd_wr_i,
	.cmd_send_i, .cmd_code_i, .cmd_wdata_i, .page_i, .vcmd_valid_i,
	.rsp_valid_o, .rsp_err_o, .thr_valid_o, .log_store_o, .fault_off_o,
	.log_restore_o, .log_clear_o, .page_mask_o, .retry_limit_o);

// >>> psmcb_host.sv
// host model issuing command reads, writes and sends
`timescale 1ns/100ps
module psmcb_host (
	// clock and answer
	input  wire logic        clk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [15:0] rsp_data_i,
	input  wire logic        rsp_err_i,
	// command strobes
	output      logic        cmd_rd_o,
	output      logic        cmd_wr_o,
	output      logic        cmd_send_o,
	output      logic [7:0]  cmd_code_o,
	output      logic [15:0] cmd_wdata_o
);
	import psmcb_pkg::*;
	logic [15:0] rdat;
	logic        rerr;
	initial
	begin
		{cmd_rd_o, cmd_wr_o, cmd_send_o} = 3'b000;
		{cmd_code_o, cmd_wdata_o} = 24'hA5C35A;
	end
	// kind 0 read, 1 write, 2 send; one-cycle strobe
	task acc(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
		int n;
		@(negedge clk_i);
		{cmd_rd_o, cmd_wr_o, cmd_send_o} = {k == 2'd0, k == 2'd1, k == 2'd2};
		{cmd_code_o, cmd_wdata_o} = {c, d};
		@(negedge clk_i);
		{cmd_rd_o, cmd_wr_o, cmd_send_o} = 3'b000;
		// idle lines carry inverted values so a late sample is caught
		{cmd_code_o, cmd_wdata_o} = ~{c, d};
		for (n = 0; n < 3 && rsp_valid_i !== 1'b1; n++)
			@(negedge clk_i);
		if (rsp_valid_i !== 1'b1)
		begin
			tb.bad_count++;
			tb.stop_test();
		end
		{rdat, rerr} = {rsp_data_i, rsp_err_i};
	endtask
endmodule // psmcb_host

// >>> psmcb_tb.sv
// self-checking bench for the manufacturer command bank
`timescale 1ns/100ps
module tb;
	import psmcb_pkg::*;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        cmd_rd_i, cmd_wr_i, cmd_send_i, rsp_valid_o, rsp_err_o;
	logic        vout_valid_i, vin_valid_i, temp_valid_i, vcmd_valid_i;
	logic        thr_valid_o, log_wr_i;
	logic [2:0]  vout_chan_i, vcmd_chan_i, thr_chan_o;
	logic [7:0]  cmd_code_i, page_i, log_status_i, shared_status_i, base_addr_o;
	logic [7:0]  log_waddr_i, log_wdata_i, page_mask_o, retry_limit_o;
	logic [15:0] cmd_wdata_i, rsp_data_o, vout_i, vin_i, temp_i, vcmd_i;
	logic [15:0] thr_o, pads_i, m;
	logic [79:0] dac_o;
	logic [31:0] fault_pin_resp_o;
	int          bad_count = 0;
	int          check_count = 0;
	logic [7:0]  rw_code [14] = '{CMD_FAULT_PIN00, CMD_FAULT_PIN01,
		CMD_FAULT_PIN10, CMD_FAULT_PIN11, CMD_INEN_OV_RESP, CMD_INEN_UV_RESP,
		CMD_RETRY_INTV, CMD_RESTART_INTV, CMD_PGOOD_DELAY, CMD_WDOG_FIRST,
		CMD_WDOG_INTV, CMD_PAGE_MASK, CMD_BASE_ADDR, CMD_RETRY_LIMIT};
	logic [15:0] rw_def [14] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'hF320, 16'hFB20, 16'hEB20, 16'h8000,
		16'h8000, 16'h00FF, 16'h005C, 16'h0007};
	always #2.5 clk_i = ~clk_i;
	psmcb_host host (.clk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
		.rsp_err_i(rsp_err_o), .cmd_rd_o(cmd_rd_i), .cmd_wr_o(cmd_wr_i),
		.cmd_send_o(cmd_send_i), .cmd_code_o(cmd_code_i),
		.cmd_wdata_o(cmd_wdata_i));
	psmcb_bank dut (.clk_i, .rstn_i, .cmd_rd_i, .cmd_wr_i, .cmd_send_i,
		.cmd_code_i, .cmd_wdata_i, .page_i, .rsp_valid_o, .rsp_data_o,
		.rsp_err_o, .vout_valid_i, .vout_chan_i, .vout_i, .vin_valid_i, .vin_i,
		.temp_valid_i, .temp_i, .vcmd_valid_i, .vcmd_chan_i, .vcmd_i,
		.thr_valid_o, .thr_chan_o, .thr_o, .pads_i, .log_status_i,
		.shared_status_i, .log_wr_i, .log_waddr_i, .log_wdata_i,
		.log_store_o(), .fault_off_o(), .log_restore_o(), .log_clear_o(),
		.fault_pin_resp_o, .inen_ov_resp_o(), .inen_uv_resp_o(),
		.retry_intv_o(), .restart_intv_o(), .pgood_delay_o(),
		.wdog_first_o(), .wdog_intv_o(), .page_mask_o, .base_addr_o,
		.retry_limit_o, .dac_o);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task rd(input logic [7:0] c, input logic [15:0] k, input logic [15:0] e);
		host.acc(2'd0, c, 16'h0000);
		chk("read data", host.rdat & k, e);
		chk("read error", {15'h0, host.rerr}, 16'h0000);
	endtask
	task refuse(input logic [1:0] k, input logic [7:0] c);
		host.acc(k, c, 16'h0123);
		chk("refusal", {15'h0, host.rerr}, 16'h0001);
	endtask
	task smp(input logic [15:0] vo, input logic [15:0] vi, input logic [15:0] t);
		@(negedge clk_i);
		{vout_valid_i, vin_valid_i, temp_valid_i, vout_chan_i} = 6'b111010;
		{vout_i, vin_i, temp_i} = {vo, vi, t};
		@(negedge clk_i);
		{vout_valid_i, vin_valid_i, temp_valid_i} = 3'b000;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end
	initial
	begin
		{vout_valid_i, vin_valid_i, temp_valid_i, vcmd_valid_i, log_wr_i} = '0;
		{vout_chan_i, vcmd_chan_i, page_i, log_waddr_i, log_wdata_i} = '0;
		{vout_i, vin_i, temp_i, vcmd_i} = '0;
		{pads_i, log_status_i, shared_status_i} = 32'h3C5A_2184;
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		// defaults, then inverted pattern written and read back
		for (int i = 0; i < 14; i++)
		begin
			m = (i > 5 && i < 11) ? 16'hFFFF : 16'h00FF;
			rd(rw_code[i], m, rw_def[i]);
			host.acc(2'd1, rw_code[i], ~rw_def[i] & m);
			rd(rw_code[i], m, ~rw_def[i] & m);
		end
		chk("mask addr", {page_mask_o, base_addr_o}, 16'h00A3);
		chk("pin resp", fault_pin_resp_o[15:0], 16'hFFFF);
		for (int p = 0; p < 8; p++)
		begin
			page_i = p[7:0];
			host.acc(2'd1, CMD_TRIM_DAC, {6'h00, p[3:0], 6'h15});
		end
		for (int p = 0; p < 8; p++)
		begin
			page_i = p[7:0];
			rd(CMD_TRIM_DAC, 16'h03FF, {6'h00, p[3:0], 6'h15});
		end
		chk("dac out", {6'h00, dac_o[79:70]}, 16'h01D5);
		page_i = 8'h08;
		refuse(2'd1, CMD_TRIM_DAC);
		page_i = 8'h05;
		rd(CMD_OFF_COEFF, 16'hFFFF, 16'hC200);
		host.acc(2'd1, CMD_OFF_COEFF, 16'hC300);
		refuse(2'd1, CMD_PART_ID);
		rd(CMD_PART_ID, 16'hFFFF, 16'h0A5A);
		refuse(2'd0, CMD_LOG_STORE);
		refuse(2'd2, CMD_PAGE_MASK);
		refuse(2'd0, 8'hF0);
		rd(CMD_LOT_CODE, 16'h00FF, 16'h0000);
		rd(CMD_PAD_STATE, 16'hFFFF, 16'h3C5A);
		rd(CMD_LOG_STATUS, 16'h00FF, 16'h0021);
		rd(CMD_SHARED_STATUS, 16'h00FF, 16'h0084);
		// trackers on channel 2, compared by value
		smp(16'h0100, 16'hD280, 16'h0019);
		smp(16'h8300, 16'hD140, 16'h07FF);
		smp(16'h0200, 16'h0009, 16'h0010);
		page_i = 8'h02;
		rd(CMD_VOUT_PEAK, 16'hFFFF, 16'h8300);
		rd(CMD_VIN_PEAK, 16'hFFFF, 16'hD280);
		rd(CMD_TEMP_PEAK, 16'hFFFF, 16'h0019);
		rd(CMD_VOUT_MIN, 16'hFFFF, 16'h0100);
		rd(CMD_VIN_MIN, 16'hFFFF, 16'hD140);
		rd(CMD_TEMP_MIN, 16'hFFFF, 16'h07FF);
		@(negedge clk_i);
		{vcmd_valid_i, vcmd_chan_i, vcmd_i} = {1'b1, 3'd5, 16'h1000};
		@(negedge clk_i);
		vcmd_valid_i = 1'b0;
		chk("threshold", thr_o, 16'h3000);
		chk("threshold chan", {12'h0, thr_valid_o, thr_chan_o}, 16'h000D);
		for (int i = 0; i < 3; i++)
		begin
			host.acc(2'd2, CMD_LOG_STORE + i[7:0], 16'h0000);
			chk("send error", {15'h0, host.rerr}, 16'h0000);
		end
		for (int i = 0; i < 255; i++)
		begin
			@(negedge clk_i);
			{log_wr_i, log_waddr_i, log_wdata_i} = {1'b1, i[7:0], i[7:0] ^ 8'h5A};
		end
		@(negedge clk_i);
		log_wr_i = 1'b0;
		for (int i = 0; i < 256; i++)
			rd(CMD_LOG_READOUT, 16'h00FF, (i == 0) ? 16'h00FF : {8'h00, (i[7:0] - 8'd1) ^ 8'h5A});
		rd(CMD_LOG_STATUS, 16'h00FF, 16'h0021);
		rd(CMD_LOG_READOUT, 16'h00FF, 16'h00FF);
		// second reset in mid-run brings defaults back
		rstn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rd(CMD_RETRY_LIMIT, 16'h00FF, 16'h0007);
		stop_test();
	end
endmodule // tb
